// ===== rtl/see_pkg.sv
// Shared constants for the serial EEPROM slave and its bus master.
// Assumes a 10 MHz system clock shared by both ends.
// Notes on behaviour
// - Page write: up to sixteen buffered data bytes
// - Ack each data byte, bump low nibble
// - Write address wraps within its page
// - Extra bytes overwrite earlier buffered bytes
// - Stop after write commits buffer once
// - Bus ignored while internal write runs
// - Master may poll right after Stop
// - No ack while busy, ack when done
// - Direction bit one selects a read
// - Counter holds last accessed address plus one
// - Read: ack, then send byte at counter
// - Master nacks single read, then Stop
// - Read after top location returns location zero
// - Random read: dummy write, repeated Start
// - Random read returns newly loaded address
// - Master ack requests next consecutive byte
// - Master ends sequential read: nack, Stop
// - Read counter wraps across whole array
// - Ack pulls data low on ninth clock
// - Type code plus chip or block select
// - Write protect pin blocks array writes
// - Start resets the transfer logic

package see_pkg;
	localparam int CLK_HZ        = 10_000_000;
	localparam int CLK_NS        = 100;
	localparam int ADDR_BITS     = 11;
	localparam int PAGE_BITS     = 4;
	localparam int WRITE_TIME_MS = 5;
	// Longest time, so the count rounds down
	localparam int WRITE_CYC     = WRITE_TIME_MS * (CLK_HZ / 1000);
	localparam int SCL_PERIOD_NS = 800;
	localparam int SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_NS);
	// Device type code; value is arbitrary
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam logic       DIR_READ = 1'h1;
	localparam logic [1:0] CMD_START = 2'h0;
	localparam logic [1:0] CMD_STOP  = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_READ  = 2'h3;
endpackage

// ===== rtl/see_if.sv
// Two-wire bus between master and EEPROM slave.
// Clock line is driven only by the master; data line is wired-AND.
`timescale 1ns/1ps
interface see_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_s_o;
	logic sda_s_oe;
	logic sda;

	// Pull-up wins unless an enabled driver pulls low
	assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

	modport dev (
		input  scl,
		input  sda,
		output sda_s_o,
		output sda_s_oe
	);
	modport host (
		output scl,
		output sda_m_o,
		output sda_m_oe,
		input  sda
	);
endinterface

// ===== rtl/see_dev.sv
// EEPROM slave: byte engine, page buffer, array and write timer.
// Assumes bus lines from another domain; ABITS between 8 and 11.
`timescale 1ns/1ps
module see_dev #(
	parameter int ABITS     = see_pkg::ADDR_BITS,
	parameter int WRITE_CYC = see_pkg::WRITE_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_wp,
	input  wire logic [2:0] i_cs,
	see_if.dev              bus,
	output logic            o_busy
);
	typedef enum logic [6:0] {
		D_IDLE = 7'h01,
		D_DEV  = 7'h02,
		D_ACK  = 7'h04,
		D_WADR = 7'h08,
		D_WDAT = 7'h10,
		D_RDAT = 7'h20,
		D_RACK = 7'h40
	} see_dstate_t;

	localparam int PB   = see_pkg::PAGE_BITS;
	localparam int PAGE = 2 ** PB;
	localparam int BB   = ABITS - 8;
	localparam int CW   = $clog2(WRITE_CYC + 1);
	// Slave address bits compared with pins; the rest pick a block
	localparam logic [2:0] CS_MASK = 3'(3'h7 << BB);

	logic [5:0]       sync1;
	logic [5:0]       sync2;
	logic             scl_d;
	logic             sda_d;
	logic             scl;
	logic             sda;
	logic             wp;
	logic [2:0]       cs;
	logic             rise;
	logic             fall;
	logic             start;
	logic             stop;

	see_dstate_t      state;
	see_dstate_t      next_state;
	see_dstate_t      after;
	see_dstate_t      next_after;
	logic [3:0]       cnt;
	logic [3:0]       next_cnt;
	logic [7:0]       sh;
	logic [7:0]       next_sh;
	logic [ABITS-1:0] addr;
	logic [ABITS-1:0] next_addr;
	logic [2:0]       blk;
	logic [2:0]       next_blk;
	logic             oe;
	logic             next_oe;
	logic             acked;
	logic             next_acked;
	logic             busy;
	logic             next_busy;
	logic [CW-1:0]    bcnt;
	logic [CW-1:0]    next_bcnt;
	logic [PAGE-1:0]  pvalid;
	logic [PAGE-1:0]  next_pvalid;
	logic             pb_we;
	logic             mem_we;
	logic             do_load;
	logic             cs_ok;
	logic [10:0]      full;
	logic [7:0]       rd_byte;

	logic [7:0]       mem  [2**ABITS];
	logic [7:0]       pbuf [PAGE];

	assign scl   = sync2[0];
	assign sda   = sync2[1];
	assign wp    = sync2[2];
	assign cs    = sync2[5:3];
	assign rise  = scl & ~scl_d;
	assign fall  = ~scl & scl_d;
	assign start = scl & scl_d & sda_d & ~sda;
	assign stop  = scl & scl_d & ~sda_d & sda;

	assign cs_ok   = ((sh[3:1] ^ cs) & CS_MASK) == 3'h0;
	assign full    = {blk, sh};
	assign rd_byte = mem[addr];
	assign mem_we  = busy & pvalid[bcnt[PB-1:0]];

	assign bus.sda_s_o  = 1'h0;
	assign bus.sda_s_oe = oe;
	assign o_busy       = busy;

	// Two stages on every pin before any logic looks at it
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			sync1 <= 6'h03;
			sync2 <= 6'h03;
			scl_d <= 1'h1;
			sda_d <= 1'h1;
		end else if (i_ce) begin
			sync1 <= {i_cs, i_wp, bus.sda, bus.scl};
			sync2 <= sync1;
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	always_comb begin
		next_state  = state;
		next_after  = after;
		next_cnt    = cnt;
		next_sh     = sh;
		next_addr   = addr;
		next_blk    = blk;
		next_oe     = oe;
		next_acked  = acked;
		next_busy   = busy;
		next_bcnt   = bcnt;
		next_pvalid = pvalid;
		pb_we       = 1'h0;
		do_load     = 1'h0;
		// Commit walks the page index as the timer counts down
		if (busy) begin
			next_bcnt = bcnt - CW'(1);
			if (bcnt == CW'(1)) begin
				next_busy   = 1'h0;
				next_pvalid = '0;
			end
		end
		if (start) begin
			next_state = D_DEV;
			next_cnt   = 4'h0;
			next_oe    = 1'h0;
		end else if (stop) begin
			next_state = D_IDLE;
			next_oe    = 1'h0;
			if (state == D_WDAT && !busy) begin
				if (|pvalid && !wp) begin
					next_busy = 1'h1;
					next_bcnt = CW'(WRITE_CYC);
				end else begin
					next_pvalid = '0;
				end
			end
		end else begin
			unique case (state)
			D_IDLE: begin
			end
			D_DEV, D_WADR, D_WDAT: begin
				if (rise && cnt != 4'h8) begin
					next_sh  = {sh[6:0], sda};
					next_cnt = cnt + 4'h1;
				end else if (fall && cnt == 4'h8) begin
					next_cnt   = 4'h0;
					next_oe    = 1'h1;
					next_state = D_ACK;
					next_after = D_WDAT;
					if (state == D_DEV) begin
						// Polling while busy sees no acknowledge
						if (sh[7:4] == see_pkg::DEV_TYPE && cs_ok &&
						    !busy) begin
							next_blk   = sh[3:1] & ~CS_MASK;
							next_after = (sh[0] == see_pkg::DIR_READ) ?
							             D_RDAT : D_WADR;
						end else begin
							next_oe    = 1'h0;
							next_state = D_IDLE;
						end
					end else if (state == D_WADR) begin
						next_addr   = full[ABITS-1:0];
						next_pvalid = '0;
					end else begin
						pb_we = 1'h1;
						next_pvalid[addr[PB-1:0]] = 1'h1;
						next_addr = {addr[ABITS-1:PB],
						             addr[PB-1:0] + PB'(1)};
					end
				end
			end
			D_ACK: begin
				if (fall) begin
					next_oe    = 1'h0;
					next_state = after;
					do_load    = (after == D_RDAT);
				end
			end
			D_RDAT: begin
				if (fall) begin
					if (cnt == 4'h7) begin
						next_oe    = 1'h0;
						next_state = D_RACK;
					end else begin
						next_sh  = {sh[6:0], 1'h0};
						next_cnt = cnt + 4'h1;
						next_oe  = ~sh[6];
					end
				end
			end
			D_RACK: begin
				if (rise) begin
					next_acked = ~sda;
				end
				if (fall) begin
					if (acked) begin
						do_load = 1'h1;
					end else begin
						next_state = D_IDLE;
					end
				end
			end
			default: begin
				next_state = D_IDLE;
				next_oe    = 1'h0;
			end
			endcase
		end
		if (do_load) begin
			next_state = D_RDAT;
			next_sh    = rd_byte;
			next_cnt   = 4'h0;
			next_oe    = ~rd_byte[7];
			next_addr  = addr + ABITS'(1);
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state  <= D_IDLE;
			after  <= D_IDLE;
			cnt    <= 4'h0;
			sh     <= 8'h00;
			addr   <= '0;
			blk    <= 3'h0;
			oe     <= 1'h0;
			acked  <= 1'h0;
			busy   <= 1'h0;
			bcnt   <= '0;
			pvalid <= '0;
		end else if (i_ce) begin
			state  <= next_state;
			after  <= next_after;
			cnt    <= next_cnt;
			sh     <= next_sh;
			addr   <= next_addr;
			blk    <= next_blk;
			oe     <= next_oe;
			acked  <= next_acked;
			busy   <= next_busy;
			bcnt   <= next_bcnt;
			pvalid <= next_pvalid;
		end
	end

	// Array has no reset; contents start undefined
	always_ff @(posedge i_clk_sys) begin
		if (i_ce) begin
			if (mem_we) begin
				mem[{addr[ABITS-1:PB], bcnt[PB-1:0]}] <=
					pbuf[bcnt[PB-1:0]];
			end
			if (pb_we) begin
				pbuf[addr[PB-1:0]] <= sh;
			end
		end
	end
endmodule

// ===== rtl/see_host.sv
// Two-wire bus master: Start, Stop, byte write and byte read commands.
// Assumes the slave answers within half a bit time.
`timescale 1ns/1ps
module see_host #(
	parameter int QTR = see_pkg::SCL_QTR_CYC
) (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_ce,
	input  wire logic       i_cmd_valid,
	input  wire logic [1:0] i_cmd_op,
	input  wire logic [7:0] i_cmd_data,
	input  wire logic       i_cmd_nack,
	output logic            o_cmd_ready,
	output logic            o_done,
	output logic [7:0]      o_rd_data,
	output logic            o_ack,
	see_if.host             bus
);
	typedef enum logic [2:0] {
		H_IDLE = 3'h1,
		H_COND = 3'h2,
		H_BYTE = 3'h4
	} see_hstate_t;

	localparam int QW = $clog2(QTR + 1);

	see_hstate_t  state;
	see_hstate_t  next_state;
	logic [1:0]   op;
	logic [1:0]   next_op;
	logic [QW-1:0] qcnt;
	logic [QW-1:0] next_qcnt;
	logic [1:0]   ph;
	logic [1:0]   next_ph;
	logic [3:0]   bitn;
	logic [3:0]   next_bitn;
	logic [8:0]   tx;
	logic [8:0]   next_tx;
	logic [8:0]   rx;
	logic [8:0]   next_rx;
	logic         scl;
	logic         next_scl;
	logic         sda;
	logic         next_sda;
	logic [7:0]   next_rd_data;
	logic         next_ack;
	logic         next_done;
	logic         s1;
	logic         s2;
	logic         tick;
	logic [1:0]   lv;

	// Levels {scl, sda} for one quarter of a condition or bit
	function automatic logic [1:0] lvl(input logic [1:0] o,
	                                   input logic [1:0] p,
	                                   input logic cur,
	                                   input logic b);
		logic [1:0] r;
		r = {1'h0, cur};
		if (o == see_pkg::CMD_START) begin
			r = (p == 2'h0) ? {1'h0, cur} : (p == 2'h1) ? 2'h1 :
			    (p == 2'h2) ? 2'h3 : 2'h2;
		end else if (o == see_pkg::CMD_STOP) begin
			r = (p == 2'h0) ? {1'h0, cur} : (p == 2'h1) ? 2'h0 :
			    (p == 2'h2) ? 2'h2 : 2'h3;
		end else if (p != 2'h0) begin
			// Data moves only while the clock is low
			r = {p[1], b};
		end
		return r;
	endfunction

	assign tick        = (qcnt == QW'(QTR - 1));
	assign o_cmd_ready = (state == H_IDLE);
	assign bus.scl     = scl;
	assign bus.sda_m_o = 1'h0;
	assign bus.sda_m_oe = ~sda;

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			s1 <= 1'h1;
			s2 <= 1'h1;
		end else if (i_ce) begin
			s1 <= bus.sda;
			s2 <= s1;
		end
	end

	always_comb begin
		next_state   = state;
		next_op      = op;
		next_qcnt    = qcnt;
		next_ph      = ph;
		next_bitn    = bitn;
		next_tx      = tx;
		next_rx      = rx;
		next_scl     = scl;
		next_sda     = sda;
		next_rd_data = o_rd_data;
		next_ack     = o_ack;
		next_done    = 1'h0;
		lv           = 2'h0;
		if (state == H_IDLE) begin
			if (i_cmd_valid) begin
				next_op   = i_cmd_op;
				next_qcnt = '0;
				next_ph   = 2'h0;
				next_bitn = 4'h0;
				// Read leaves data released, ninth bit is our answer
				next_tx   = (i_cmd_op == see_pkg::CMD_WRITE) ?
				            {i_cmd_data, 1'h1} :
				            {8'hFF, i_cmd_nack};
				next_state = (i_cmd_op[1] == 1'h0) ? H_COND : H_BYTE;
				lv         = lvl(i_cmd_op, 2'h0, sda, 1'h1);
				next_scl   = lv[1];
				next_sda   = lv[0];
			end
		end else begin
			next_qcnt = tick ? '0 : qcnt + QW'(1);
			if (tick) begin
				next_ph = ph + 2'h1;
				if (ph == 2'h3) begin
					if (state == H_BYTE) begin
						next_rx = {rx[7:0], s2};
					end
					if (state == H_COND || bitn == 4'h8) begin
						next_state   = H_IDLE;
						next_done    = 1'h1;
						next_rd_data = next_rx[8:1];
						next_ack     = ~next_rx[0];
					end else begin
						next_bitn = bitn + 4'h1;
						next_tx   = {tx[7:0], 1'h1};
					end
				end else begin
					lv       = lvl(op, next_ph, sda, tx[8]);
					next_scl = lv[1];
					next_sda = lv[0];
				end
				if (ph == 2'h3 && next_state != H_IDLE) begin
					lv       = lvl(op, 2'h0, sda, 1'h1);
					next_scl = lv[1];
					next_sda = lv[0];
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state     <= H_IDLE;
			op        <= see_pkg::CMD_STOP;
			qcnt      <= '0;
			ph        <= 2'h0;
			bitn      <= 4'h0;
			tx        <= 9'h1FF;
			rx        <= 9'h000;
			scl       <= 1'h1;
			sda       <= 1'h1;
			o_rd_data <= 8'h00;
			o_ack     <= 1'h0;
			o_done    <= 1'h0;
		end else if (i_ce) begin
			state     <= next_state;
			op        <= next_op;
			qcnt      <= next_qcnt;
			ph        <= next_ph;
			bitn      <= next_bitn;
			tx        <= next_tx;
			rx        <= next_rx;
			scl       <= next_scl;
			sda       <= next_sda;
			o_rd_data <= next_rd_data;
			o_ack     <= next_ack;
			o_done    <= next_done;
		end
	end
endmodule

// ===== verif/see_checker.sv
// Checker for the two-wire link between the master and the EEPROM slave.
// Assumes the host runs with QTR of 3, so each clock high lasts at least six cycles.
`timescale 1ns/1ps
module see_checker #(
	parameter int WRITE_CYC = 400
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic scl,
	input wire logic sda_m_o,
	input wire logic sda_s_o,
	input wire logic sda_s_oe,
	input wire logic sda,
	input wire logic o_busy,
	input wire logic i_wp
);
	int cnt;
	int next_cnt;

	// Busy run length, cleared whenever busy drops
	always_comb begin
		next_cnt = o_busy ? cnt + 1 : 0;
	end
	always_ff @(posedge i_clk_sys) begin
		cnt <= i_rst_n ? next_cnt : 0;
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	open_drain_a: assert property (
		!sda_s_o && !sda_m_o)
		else $error("driver value not low");
	oe_stable_a: assert property (
		scl && $past(scl) |-> $stable(sda_s_oe))
		else $error("slave data changed while clock high");
	busy_len_a: assert property (
		$fell(o_busy) |-> cnt == WRITE_CYC)
		else $error("write cycle length wrong");
	busy_quiet_a: assert property (
		o_busy |-> !sda_s_oe)
		else $error("slave drove data while busy");
	wp_block_a: assert property (
		$rose(o_busy) |-> !i_wp)
		else $error("write cycle started while protected");
	reset_idle_a: assert property (
		$rose(i_rst_n) |-> !sda_s_oe && !o_busy)
		else $error("slave not idle after reset");
	start_quiet_a: assert property (
		scl && $past(scl) && $fell(sda) |-> ##4 !sda_s_oe [*8])
		else $error("slave drove data right after start");
	// Six cycles is two quarters at QTR of 3
	scl_high_a: assert property (
		$rose(scl) |-> scl [*6])
		else $error("clock high phase too short");
endmodule

// ===== verif/see_bench.sv
// Bench: the bus master drives the EEPROM slave across the link.
// Assumes one 10 MHz clock for both ends and a short write cycle.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
	mismatches++; $display("[ERR] %0t got %h want %h", $time, g, e); end end
module see_bench;
	// Shortened write cycle, still longer than one poll
	localparam int WCYC = 400;
	logic        clk;
	logic        rst_n;
	logic        wp;
	logic        c_valid;
	logic [1:0]  c_op;
	logic [7:0]  c_data;
	logic        c_nack;
	logic        ready;
	logic        done;
	logic        ack;
	logic        busy;
	logic [7:0]  rdd;
	logic [7:0]  exp_mem [0:2047];
	logic [10:0] ptr;
	int          mismatches = 0;
	int          num_checks = 0;

	see_if u_see_if ();
	see_dev #(.ABITS(11), .WRITE_CYC(WCYC)) u_see_dev (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_wp(wp),
		.i_cs(3'h0), .bus(u_see_if), .o_busy(busy));
	see_host #(.QTR(3)) u_see_host (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1),
		.i_cmd_valid(c_valid), .i_cmd_op(c_op), .i_cmd_data(c_data),
		.i_cmd_nack(c_nack), .o_cmd_ready(ready), .o_done(done),
		.o_rd_data(rdd), .o_ack(ack), .bus(u_see_if));
	see_checker #(.WRITE_CYC(WCYC)) u_see_checker (
		.i_clk_sys(clk), .i_rst_n(rst_n), .scl(u_see_if.scl),
		.sda_m_o(u_see_if.sda_m_o), .sda_s_o(u_see_if.sda_s_o),
		.sda_s_oe(u_see_if.sda_s_oe), .sda(u_see_if.sda),
		.o_busy(busy), .i_wp(wp));

	always #50 clk = ~clk;

	task automatic test_done();
		if (mismatches == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cmd(input logic [1:0] op, input logic [7:0] d,
			input logic nk);
		int n;
		c_valid <= 1'b1;
		c_op <= op;
		c_data <= d;
		c_nack <= nk;
		@(posedge clk);
		c_valid <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 2000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 2000) begin
			mismatches++;
			$display("[ERR] %0t command timeout", $time);
			test_done();
		end
	endtask

	task automatic st();
		cmd(see_pkg::CMD_START, 8'h00, 1'b0);
	endtask
	task automatic sp();
		cmd(see_pkg::CMD_STOP, 8'h00, 1'b0);
	endtask
	task automatic wb(input logic [7:0] d);
		cmd(see_pkg::CMD_WRITE, d, 1'b0);
	endtask
	task automatic dev(input logic [2:0] b, input logic rd);
		st();
		wb({see_pkg::DEV_TYPE, b, rd});
	endtask

	// Start, device address for write, then byte address
	task automatic at(input logic [10:0] a);
		dev(a[10:8], 1'b0);
		`CHK(ack, 1'b1)
		wb(a[7:0]);
		`CHK(ack, 1'b1)
		ptr = a;
	endtask

	task automatic wr(input logic [10:0] a, input int n,
			input logic [7:0] s, input logic ab);
		at(a);
		for (int i = 0; i < n; i++) begin
			wb(s + i[7:0]);
			`CHK(ack, 1'b1)
			if (!wp && !ab)
				exp_mem[{a[10:4], a[3:0] + i[3:0]}] = s + i[7:0];
		end
		if (ab)
			st();
		sp();
		ptr = {a[10:4], a[3:0] + n[3:0]};
	endtask

	task automatic poll();
		logic got;
		for (int k = 0; k < 30; k++) begin
			`CHK(ready, 1'h1)
			dev(3'h0, 1'b0);
			got = ack;
			sp();
			if (k == 0)
				`CHK(got, 1'b0)
			if (got === 1'b1)
				break;
		end
		`CHK(got, 1'b1)
	endtask

	task automatic cur(input int n);
		dev(3'h0, 1'b1);
		`CHK(ack, 1'b1)
		for (int i = 0; i < n; i++) begin
			cmd(see_pkg::CMD_READ, 8'h00, i == n - 1);
			`CHK(rdd, exp_mem[ptr])
			ptr = ptr + 11'h001;
		end
		sp();
	endtask

	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		wp = 1'b0;
		c_valid = 1'b0;
		c_op = 2'h0;
		c_data = 8'h00;
		c_nack = 1'b0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		wr(11'h000, 2, 8'hA0, 1'b0);
		poll();
		wr(11'h7FD, 18, 8'h30, 1'b0);
		poll();
		cur(1);
		cur(1);
		at(11'h7FE);
		cur(4);
		// Protect held until the Stop has long been seen
		wp <= 1'b1;
		wr(11'h001, 1, 8'h55, 1'b0);
		repeat (20) @(posedge clk);
		wp <= 1'b0;
		wr(11'h000, 1, 8'h77, 1'b1);
		at(11'h000);
		cur(2);
		st();
		wb({see_pkg::DEV_TYPE ^ 4'h3, 4'h0});
		`CHK(ack, 1'b0)
		sp();
		test_done();
	end
endmodule
